// [logic/sns_defs.vh]
// constants for the sweep sensor navigation, click and heating block
// assumes a 50 MHz system clock that stands for the internal oscillator
// Functional notes
// - frame pixel bits shifted out one per sck step, four steps per pixel
// - interrupt on action; host reads status
// - stream mode interrupts on motion or button change
// - remote mode never interrupts; results wait polling
// - result registers cleared after each host read
// - click and navigation may run together
// - signed x/y counts accumulate, cleared on read
// - nav control bits 6:5 select slice rate
// - nav rate divider lowers navigation slice rate
// - click sets status b7 and navgen b1
// - click sampled at 90 Hz, divider adjustable
// - heat plus watchdog bits heat one period
// - new heat request accepted after period ends
// - heating power selects 50 or 100 mW
// - mode pattern 00001xx enters standby, stops oscillator
// - command word b7 high, b6 read, b5:2 address
`ifndef SNS_DEFS_VH
`define SNS_DEFS_VH
// register indexes, byte address is four times the index
`define SNS_IDX_STATUS 4'h0
`define SNS_IDX_NAVCTRL 4'h1
`define SNS_IDX_NAVDIV 4'h2
`define SNS_IDX_CLKDIV 4'h3
`define SNS_IDX_HEAT 4'h4
`define SNS_IDX_MODE 4'h5
`define SNS_IDX_NAVGEN 4'h6
`define SNS_IDX_NAVX 4'h7
`define SNS_IDX_NAVY 4'h8
// field positions
`define SNS_ST_CLICK 7
`define SNS_ST_HEAT 6
`define SNS_ST_MOVE 0
`define SNS_NAV_RATE_HI 6
`define SNS_NAV_RATE_LO 5
`define SNS_NAV_EN 0
`define SNS_HEAT_REQ 6
`define SNS_HEAT_WD 5
`define SNS_HEAT_PWR 0
`define SNS_MODE_ACQ 4
`define SNS_MODE_STREAM 3
`define SNS_MODE_CLICK_EN 1
`define SNS_MODE_STBY_PAT 5'h01
`define SNS_NG_CLICK 1
`define SNS_NG_MOVE 0
// command word fields
`define SNS_CMD_FLAG 7
`define SNS_CMD_RD 6
// reset values
`define SNS_RST_NAVCTRL 8'h20
`define SNS_RST_REG 8'h00
// timing
`define SNS_SYS_HZ 50000000
`define SNS_NAV_F0_HZ 5800
`define SNS_NAV_F1_HZ 2900
`define SNS_NAV_F2_HZ 1900
`define SNS_NAV_F3_HZ 1500
`define SNS_CLICK_HZ 90
`define SNS_WD_S 4
// frame geometry and start-of-frame pattern
`define SNS_FRM_LAST_COL 8'he8
`define SNS_FRM_LAST_ROW 3'h7
`define SNS_SYNC_PAT 32'hf0f00200
`endif

// [logic/sns_sync.v]
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module sns_sync #(
  parameter W = 4,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire sys_clk, // system clock
  input wire rst, // async reset, high
  input wire [W-1:0] d, // raw pins
  output reg [W-1:0] q // synchronised pins
);
  reg [W-1:0] meta_ff; // first stage, read only by q

  // idle level as reset value so no false edge at release
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // sns_sync
`default_nettype wire

// [logic/sns_tick.v]
// periodic tick generator with a run-time period
// assumes period is at least one cycle and stable while enabled
`timescale 1ns/1ps
`default_nettype none
module sns_tick (
  input wire sys_clk, // system clock
  input wire rst, // async reset, high
  input wire en, // run; low clears the count
  input wire [31:0] period, // cycles per tick
  output reg tick // one-cycle pulse
);
  reg [31:0] cnt_ff; // cycles since last tick

  // restart from zero whenever disabled
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= 32'h0;
      tick <= 1'b0;
    end
    else if (!en)
    begin
      cnt_ff <= 32'h0;
      tick <= 1'b0;
    end
    else if (cnt_ff >= period - 32'h1)
    begin
      cnt_ff <= 32'h0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // sns_tick
`default_nettype wire

// [logic/sns_top.v]
// sweep sensor navigation, click, heating and serial readout logic
// assumes wishbone master on sys_clk; serial pins are asynchronous
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "sns_defs.vh"
module sns_top #(
  parameter [31:0] NAV_CYC_0 = `SNS_SYS_HZ / `SNS_NAV_F0_HZ,
  parameter [31:0] NAV_CYC_1 = `SNS_SYS_HZ / `SNS_NAV_F1_HZ,
  parameter [31:0] NAV_CYC_2 = `SNS_SYS_HZ / `SNS_NAV_F2_HZ,
  parameter [31:0] NAV_CYC_3 = `SNS_SYS_HZ / `SNS_NAV_F3_HZ,
  parameter [31:0] CLICK_CYC = `SNS_SYS_HZ / `SNS_CLICK_HZ,
  parameter [31:0] WD_CYC = `SNS_SYS_HZ * `SNS_WD_S
) (
  input wire sys_clk, // system clock, 50 MHz
  input wire rst, // async reset, high
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write
  input wire [5:0] wb_adr_i, // byte address
  input wire [3:0] wb_sel_i, // byte lanes
  input wire [31:0] wb_dat_i, // write data
  output reg [31:0] wb_dat_o, // read data
  output reg wb_ack_o, // acknowledge
  input wire sck_i, // serial clock from host
  input wire ctl_sel_n_i, // control port select, low
  input wire frm_sel_n_i, // frame port select, low
  input wire mosi_i, // serial data in
  output reg miso_o, // serial data out
  output reg miso_oe_o, // miso drive enable
  output reg [7:0] pix_col_o, // pixel column address
  output reg [2:0] pix_row_o, // pixel row address
  input wire [3:0] pix_data_i, // addressed pixel sample
  input wire [1:0] nav_dx_i, // signed x step per slice
  input wire [1:0] nav_dy_i, // signed y step per slice
  input wire click_det_i, // click array sees touch
  output reg irq_o, // interrupt, high
  output reg heat_on_o, // die heater on
  output reg heat_pwr_hi_o, // heater at 100 mW, else 50
  output reg standby_o // oscillator stopped
);
  // synchronised pins, sck idles high, selects idle high
  wire [3:0] pin_s; // {sck, ctl_sel_n, frm_sel_n, mosi}
  reg sck_prev_ff; // last sck sample
  wire sck_s = pin_s[3]; // synced clock level
  wire css_n = pin_s[2]; // synced control select
  wire fss_n = pin_s[1]; // synced frame select
  wire mosi_s = pin_s[0]; // synced data
  wire sck_rise = sck_s & ~sck_prev_ff; // sample edge
  wire sck_fall = ~sck_s & sck_prev_ff; // launch edge

  // control registers
  reg [7:0] navctrl_ff; // rate select and enable
  reg [7:0] navdiv_ff; // nav_rate_divider
  reg [7:0] clkdiv_ff; // click_rate_divider
  reg [7:0] heat_ff; // heating_control
  reg [7:0] mode_ff; // operating_mode_control
  // result registers
  reg click_st_ff; // status click flag
  reg move_st_ff; // status motion flag
  reg click_ng_ff; // navgen click flag
  reg move_ng_ff; // navgen motion flag
  reg [7:0] nav_x_ff; // signed x count
  reg [7:0] nav_y_ff; // signed y count
  reg click_prev_ff; // click level at last sample

  // control serial port state
  reg [7:0] rx_ff; // incoming shift register
  reg [2:0] bcnt_ff; // bit within byte
  reg [7:0] tx_ff; // outgoing shift register
  reg cmd_ok_ff; // a command byte has been seen
  reg cmd_rd_ff; // command is a read
  reg [3:0] addr_ff; // current register index

  // frame port state
  reg [1:0] fbit_ff; // bit within pixel nibble
  reg [3:0] nib_ff; // nibble being shifted

  sns_sync #(.W(4), .INIT(4'he)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({sck_i, ctl_sel_n_i, frm_sel_n_i, mosi_i}),
    .q(pin_s)
  );

  // standby pattern stops the oscillator-driven timers
  wire osc_stop = (mode_ff[6:2] == `SNS_MODE_STBY_PAT);
  wire stream = mode_ff[`SNS_MODE_STREAM]; // stream vs remote

  // register read view
  function [7:0] rd_mux;
    input [3:0] idx;
    begin
      case (idx)
        `SNS_IDX_STATUS: rd_mux = {click_st_ff, heat_on_o, 5'h0, move_st_ff};
        `SNS_IDX_NAVCTRL: rd_mux = navctrl_ff;
        `SNS_IDX_NAVDIV: rd_mux = navdiv_ff;
        `SNS_IDX_CLKDIV: rd_mux = clkdiv_ff;
        `SNS_IDX_HEAT: rd_mux = heat_ff;
        `SNS_IDX_MODE: rd_mux = mode_ff;
        `SNS_IDX_NAVGEN: rd_mux = {6'h0, click_ng_ff, move_ng_ff};
        `SNS_IDX_NAVX: rd_mux = nav_x_ff;
        `SNS_IDX_NAVY: rd_mux = nav_y_ff;
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  // wishbone decode, one request per acknowledged cycle
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o; // new request
  wire [3:0] wb_idx = wb_adr_i[5:2]; // register index
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0]; // write low lane
  wire wb_rd = wb_req & ~wb_we_i; // read

  // serial byte completion
  wire [7:0] byte_w = {rx_ff[6:0], mosi_s}; // byte incl. last bit
  wire byte_done = sck_rise & ~css_n & (bcnt_ff == 3'h7);
  wire is_cmd = byte_w[`SNS_CMD_FLAG];
  wire spi_wr = byte_done & ~is_cmd & cmd_ok_ff & ~cmd_rd_ff;
  wire spi_rd = byte_done &
    (is_cmd ? byte_w[`SNS_CMD_RD] : (cmd_ok_ff & cmd_rd_ff));
  // reads walk upward so three dummies return navgen, x, y
  wire [3:0] spi_rd_idx = is_cmd ? byte_w[5:2] : addr_ff + 4'h1;

  // shared write port; bus wins a same-cycle collision
  wire wr_en = wb_wr | spi_wr; // any write
  wire [3:0] wr_idx = wb_wr ? wb_idx : addr_ff; // target
  wire [7:0] wr_data = wb_wr ? wb_dat_i[7:0] : {1'b0, byte_w[6:0]};

  // read side effects from either port
  wire clr_st = (wb_rd & wb_idx == `SNS_IDX_STATUS) |
    (spi_rd & spi_rd_idx == `SNS_IDX_STATUS);
  wire clr_ng = (wb_rd & wb_idx == `SNS_IDX_NAVGEN) |
    (spi_rd & spi_rd_idx == `SNS_IDX_NAVGEN);
  wire clr_x = (wb_rd & wb_idx == `SNS_IDX_NAVX) |
    (spi_rd & spi_rd_idx == `SNS_IDX_NAVX);
  wire clr_y = (wb_rd & wb_idx == `SNS_IDX_NAVY) |
    (spi_rd & spi_rd_idx == `SNS_IDX_NAVY);

  // slice rate: base period by rate code, stretched by divider
  reg [31:0] nav_base; // cycles per slice before divide
  always @*
  begin
    case (navctrl_ff[`SNS_NAV_RATE_HI:`SNS_NAV_RATE_LO])
      2'b00: nav_base = NAV_CYC_0;
      2'b01: nav_base = NAV_CYC_1;
      2'b10: nav_base = NAV_CYC_2;
      default: nav_base = NAV_CYC_3;
    endcase
  end
  wire [31:0] nav_per = nav_base * ({24'h0, navdiv_ff} + 32'h1);
  wire [31:0] clk_per = CLICK_CYC * ({24'h0, clkdiv_ff} + 32'h1);

  // nav and click timers run independently of each other
  wire nav_tk; // navigation slice pulse
  wire clk_tk; // click slice pulse
  wire wd_end; // watchdog period over
  wire wd_run = heat_ff[`SNS_HEAT_REQ] & heat_ff[`SNS_HEAT_WD] & ~osc_stop;

  sns_tick u_nav_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .en(navctrl_ff[`SNS_NAV_EN] & ~osc_stop),
    .period(nav_per),
    .tick(nav_tk)
  );

  sns_tick u_click_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .en(mode_ff[`SNS_MODE_CLICK_EN] & ~osc_stop),
    .period(clk_per),
    .tick(clk_tk)
  );

  // watchdog counts only while the oscillator runs
  sns_tick u_wd_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .en(wd_run),
    .period(WD_CYC),
    .tick(wd_end)
  );

  // events of one slice
  wire [7:0] step_x = nav_tk ? {{6{nav_dx_i[1]}}, nav_dx_i} : 8'h00;
  wire [7:0] step_y = nav_tk ? {{6{nav_dy_i[1]}}, nav_dy_i} : 8'h00;
  wire move_ev = nav_tk & ((nav_dx_i != 2'b00) | (nav_dy_i != 2'b00));
  wire click_ev = clk_tk & click_det_i & ~click_prev_ff;
  wire btn_ev = clk_tk & (click_det_i != click_prev_ff); // button change

  // control register writes; watchdog expiry drops the request
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      navctrl_ff <= `SNS_RST_NAVCTRL;
      navdiv_ff <= `SNS_RST_REG;
      clkdiv_ff <= `SNS_RST_REG;
      heat_ff <= `SNS_RST_REG;
      mode_ff <= `SNS_RST_REG;
    end
    else
    begin
      if (wr_en & wr_idx == `SNS_IDX_NAVCTRL)
        navctrl_ff <= wr_data;
      if (wr_en & wr_idx == `SNS_IDX_NAVDIV)
        navdiv_ff <= wr_data;
      if (wr_en & wr_idx == `SNS_IDX_CLKDIV)
        clkdiv_ff <= wr_data;
      if (wr_en & wr_idx == `SNS_IDX_MODE)
        mode_ff <= wr_data;
      // a fresh write beats expiry so re-arming is never lost
      if (wr_en & wr_idx == `SNS_IDX_HEAT)
        heat_ff <= wr_data;
      else if (wd_end)
        heat_ff[`SNS_HEAT_REQ] <= 1'b0;
    end
  end

  // sticky results; a new event beats a same-cycle read clear
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      click_st_ff <= 1'b0;
      move_st_ff <= 1'b0;
      click_ng_ff <= 1'b0;
      move_ng_ff <= 1'b0;
      nav_x_ff <= 8'h00;
      nav_y_ff <= 8'h00;
      click_prev_ff <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      click_st_ff <= click_ev | (click_st_ff & ~clr_st);
      move_st_ff <= move_ev | (move_st_ff & ~clr_st);
      click_ng_ff <= click_ev | (click_ng_ff & ~clr_ng);
      move_ng_ff <= move_ev | (move_ng_ff & ~clr_ng);
      // counts wrap at 8 bits; host must read often enough
      nav_x_ff <= (clr_x ? 8'h00 : nav_x_ff) + step_x;
      nav_y_ff <= (clr_y ? 8'h00 : nav_y_ff) + step_y;
      if (clk_tk)
        click_prev_ff <= click_det_i;
      // remote mode holds results and keeps the line quiet
      if (!stream)
        irq_o <= 1'b0;
      else
        irq_o <= move_ev | btn_ev | (irq_o & ~clr_st);
    end
  end

  // heater and status outputs
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      heat_on_o <= 1'b0;
      heat_pwr_hi_o <= 1'b0;
      standby_o <= 1'b0;
    end
    else
    begin
      heat_on_o <= heat_ff[`SNS_HEAT_REQ] & ~wd_end;
      heat_pwr_hi_o <= heat_ff[`SNS_HEAT_PWR];
      standby_o <= osc_stop;
    end
  end

  // control port: sample on sck rise, launch on sck fall
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sck_prev_ff <= 1'b1;
      rx_ff <= 8'h00;
      bcnt_ff <= 3'h0;
      tx_ff <= 8'h00;
      cmd_ok_ff <= 1'b0;
      cmd_rd_ff <= 1'b0;
      addr_ff <= 4'h0;
    end
    else
    begin
      sck_prev_ff <= sck_s;
      if (css_n)
      begin
        // deselect realigns bytes, unlike a pure pin-reset scheme
        bcnt_ff <= 3'h0;
        cmd_ok_ff <= 1'b0;
      end
      else if (sck_rise)
      begin
        rx_ff <= byte_w;
        bcnt_ff <= bcnt_ff + 3'h1;
        if (byte_done & is_cmd)
        begin
          cmd_ok_ff <= 1'b1;
          cmd_rd_ff <= byte_w[`SNS_CMD_RD];
          addr_ff <= byte_w[5:2];
        end
        else if (byte_done & cmd_ok_ff & cmd_rd_ff)
          addr_ff <= spi_rd_idx;
        if (spi_rd)
          tx_ff <= rd_mux(spi_rd_idx);
      end
      else if (sck_fall)
        tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  // frame port: dummy column carries the sync pattern
  wire frm_act = ~fss_n & mode_ff[`SNS_MODE_ACQ]; // acquisition read
  wire [31:0] pat_sh = `SNS_SYNC_PAT << {pix_row_o, 2'b00};
  wire [3:0] cur_nib = (pix_col_o == 8'h00) ? pat_sh[31:28] : pix_data_i;
  wire last_row = (pix_row_o == `SNS_FRM_LAST_ROW); // column end
  wire last_col = (pix_col_o == `SNS_FRM_LAST_COL); // frame end

  // one nibble per four sck falls, rows then columns
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fbit_ff <= 2'h0;
      nib_ff <= 4'h0;
      pix_row_o <= 3'h0;
      pix_col_o <= 8'h00;
    end
    else if (!frm_act)
    begin
      // deselect restarts at the frame start
      fbit_ff <= 2'h0;
      pix_row_o <= 3'h0;
      pix_col_o <= 8'h00;
    end
    else if (sck_fall)
    begin
      fbit_ff <= fbit_ff + 2'h1;
      if (fbit_ff == 2'h0)
        nib_ff <= {cur_nib[2:0], 1'b0};
      else
        nib_ff <= {nib_ff[2:0], 1'b0};
      if (fbit_ff == 2'h3)
      begin
        pix_row_o <= pix_row_o + 3'h1;
        if (last_row)
          pix_col_o <= last_col ? 8'h00 : pix_col_o + 8'h01;
      end
    end
  end

  // shared miso; control port wins if both selects are low
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end
    else
    begin
      miso_oe_o <= ~css_n | frm_act;
      if (sck_fall & ~css_n)
        miso_o <= tx_ff[7];
      else if (sck_fall & frm_act)
        miso_o <= (fbit_ff == 2'h0) ? cur_nib[3] : nib_ff[3];
    end
  end

  // wishbone slave: ack one cycle after the request
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_rd)
        wb_dat_o <= {24'h0, rd_mux(wb_idx)};
      else if (wb_req)
        wb_dat_o <= 32'h0;
    end
  end
endmodule // sns_top
`default_nettype wire

// [verif/sns_host_mdl.sv]
// host side model: serial master on the control port
// assumes sck idles high, data moves on falls, is sampled on rises
`timescale 1ns/1ps
`default_nettype none
module sns_host_mdl (
  output var logic sck_o, // serial clock, idle high
  output var logic ctl_sel_n_o, // control select, low
  output var logic frm_sel_n_o, // frame select, low
  output var logic mosi_o, // data to device
  input wire logic miso_i, // data from device
  input wire logic miso_oe_i // device drives miso
);
  localparam time HALF = 80; // 160 ns link period, kept steady
  logic last_bit; // last level seen on miso
  initial
  begin
    sck_o = 1'b1;
    ctl_sel_n_o = 1'b1;
    frm_sel_n_o = 1'b1; // frame port idle until a frame read
    mosi_o = 1'b0;
    last_bit = 1'b0;
  end
  // one byte msb first; clock stands high between bytes
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    int i;
    for (i = 7; i >= 0; i--)
    begin
      #HALF sck_o = 1'b0;
      mosi_o = tx[i];
      #HALF sck_o = 1'b1;
      // a released line is taken as the inverse of its last level
      last_bit = miso_oe_i ? miso_i : ~last_bit;
      rx[i] = last_bit;
    end
  endtask
  // command then nb data bytes; replies collected oldest first
  task txn(input logic rd, input logic [3:0] idx, input logic [23:0] dat,
           input int nb, output logic [23:0] rsp);
    logic [7:0] r;
    int k;
    #7; // keep link edges off the system clock edges
    ctl_sel_n_o = 1'b0;
    xfer({1'b1, rd, idx, 2'b00}, r);
    rsp = 24'h0;
    for (k = 0; k < nb; k++)
    begin
      xfer({1'b0, dat[22 - 8 * k -: 7]}, r);
      rsp = {rsp[15:0], r};
    end
    #HALF ctl_sel_n_o = 1'b1;
    #(4 * HALF);
  endtask
  // frame port: n bytes of pixel bits, oldest in the top byte
  task frame(input int n, output logic [39:0] rsp);
    logic [7:0] r;
    int k;
    #7; // keep link edges off the system clock edges
    frm_sel_n_o = 1'b0;
    rsp = 40'h0;
    for (k = 0; k < n; k++)
    begin
      xfer(8'h00, r);
      rsp = {rsp[31:0], r};
    end
    #HALF frm_sel_n_o = 1'b1;
    #(4 * HALF);
  endtask
endmodule // sns_host_mdl
`default_nettype wire

// [verif/sns_props.sv]
// checker for the sensor control block, seen only at its ports
// assumes bind into sns_top; registers written over wishbone only
`timescale 1ns/1ps
`default_nettype none
module sns_props #(
  parameter [31:0] WD_CYC = 32'd200
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [5:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic irq_o, // interrupt
  input wire logic heat_on_o, // heater on
  input wire logic heat_pwr_hi_o, // heater power high
  input wire logic standby_o // standby
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic stream_ff; // mirror of the stream mode bit
  logic wd_ff; // mirror of the watchdog enable
  logic [31:0] heat_cnt_ff; // cycles the heater has stayed on
  logic wr_ok; // acked write on the low lane
  assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
  // mirrors follow bus writes only; serial writes would fool them
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stream_ff <= 1'b0;
      wd_ff <= 1'b0;
      heat_cnt_ff <= 32'h0;
    end
    else
    begin
      if (wr_ok && wb_adr_i[5:2] == 4'h5)
        stream_ff <= wb_dat_i[3];
      if (wr_ok && wb_adr_i[5:2] == 4'h4)
        wd_ff <= wb_dat_i[5];
      heat_cnt_ff <= heat_on_o ? heat_cnt_ff + 32'h1 : 32'h0;
    end
  end
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  property p_zero_dat;
    wb_ack_o && (wb_we_i || wb_adr_i[5:2] > 4'h8) |-> wb_dat_o == 32'h0;
  endproperty
  a_zero_dat: assert property (p_zero_dat) else $error("bad rdata");
  property p_heat_start;
    wr_ok && wb_adr_i[5:2] == 4'h4 && wb_dat_i[6] |-> ##[0:2] heat_on_o;
  endproperty
  a_heat_start: assert property (p_heat_start) else $error("no heat");
  property p_heat_stop;
    wd_ff |-> heat_cnt_ff <= WD_CYC + 32'd4;
  endproperty
  a_heat_stop: assert property (p_heat_stop) else $error("heat long");
  property p_heat_len;
    $fell(heat_on_o) && wd_ff |-> heat_cnt_ff + 32'd3 >= WD_CYC;
  endproperty
  a_heat_len: assert property (p_heat_len) else $error("heat short");
  property p_pwr;
    wr_ok && wb_adr_i[5:2] == 4'h4 && wb_dat_i[6]
      |-> ##2 heat_pwr_hi_o == $past(wb_dat_i[0], 2);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power level");
  property p_standby;
    wr_ok && wb_adr_i[5:2] == 4'h5
      |-> ##2 standby_o == ($past(wb_dat_i[6:2], 2) == 5'h01);
  endproperty
  a_standby: assert property (p_standby) else $error("standby");
  property p_irq_remote;
    $rose(irq_o) |-> stream_ff;
  endproperty
  a_irq_remote: assert property (p_irq_remote) else $error("irq");
  property p_irq_clear;
    wb_ack_o && !wb_we_i && wb_adr_i[5:2] == 4'h0 |=> !irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq held");
endmodule // sns_props
`default_nettype wire

// [verif/tb_top.sv]
// bench: bus tasks and a serial host drive the sensor control block
// assumes shortened timer counts handed to the design below
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam [31:0] WD = 32'd200; // shortened watchdog
  logic sys_clk = 1'b0; // 50 MHz
  logic rst = 1'b1; // async reset
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0; // bus request
  logic [5:0] wb_adr = 6'h0; // byte address
  logic [3:0] wb_sel = 4'h1; // byte lanes
  logic [3:0] pix = 4'h0; // pixel sample, follows the address
  wire logic [7:0] pcol; // pixel column
  wire logic [2:0] prow; // pixel row
  logic [31:0] wb_dat = 32'h0; // write data
  logic [1:0] dx = 2'b00, dy = 2'b00; // motion steps
  logic click = 1'b0; // click array level
  wire logic [31:0] rdat; // read data
  wire logic ack, sck, ctl_sel_n, frm_sel_n, mosi, miso, miso_oe;
  wire logic irq, heat_on, pwr_hi, standby; // block outputs
  int err_total = 0, tests_run = 0, cyc_cnt = 0;
  sns_top #(.NAV_CYC_0(32'd40), .NAV_CYC_1(32'd80), .NAV_CYC_2(32'd120),
    .NAV_CYC_3(32'd160), .CLICK_CYC(32'd50), .WD_CYC(WD)) dut (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(rdat), .wb_ack_o(ack), .sck_i(sck),
    .ctl_sel_n_i(ctl_sel_n), .frm_sel_n_i(frm_sel_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .pix_col_o(pcol), .pix_row_o(prow),
    .pix_data_i(pix), .nav_dx_i(dx), .nav_dy_i(dy), .click_det_i(click),
    .irq_o(irq), .heat_on_o(heat_on), .heat_pwr_hi_o(pwr_hi),
    .standby_o(standby));
  sns_host_mdl host (.sck_o(sck), .ctl_sel_n_o(ctl_sel_n),
    .frm_sel_n_o(frm_sel_n), .mosi_o(mosi), .miso_i(miso),
    .miso_oe_i(miso_oe));
  always #10 sys_clk = ~sys_clk;
  // pixel array stand-in: sample is column plus row, so order shows
  always @(posedge sys_clk)
    pix <= pcol[3:0] + {1'b0, prow};
  // hang guard
  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 30000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk_rng(input logic [31:0] got, input logic [31:0] lo,
               input logic [31:0] hi);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    chk_rng(got, exp, exp);
  endtask
  // one classic cycle; held until ack is seen, released at that edge
  task wb_xfer(input logic we, input logic [3:0] idx, input logic [7:0] d,
               output logic [7:0] q);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_dat <= {24'h0, d};
    @(negedge sys_clk);
    while (ack !== 1'b1)
      @(negedge sys_clk);
    @(posedge sys_clk);
    q = rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task wb_wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb_xfer(1'b1, idx, d, q);
  endtask
  task rd_chk(input logic [3:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb_xfer(1'b0, idx, 8'h0, q);
    chk({24'h0, q}, {24'h0, exp});
  endtask
  initial
  begin : main
    logic [7:0] q;
    logic [23:0] rsp;
    logic [39:0] fr;
    int c, n, e;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd_chk(4'h1, 8'h20);
    wb_wr(4'h0, 8'hff);
    rd_chk(4'h0, 8'h00);
    rd_chk(4'h9, 8'h00);
    // a write without the low lane is acked but leaves the register
    wb_sel <= 4'h0;
    wb_wr(4'h2, 8'h55);
    wb_sel <= 4'h1;
    rd_chk(4'h2, 8'h00);
    // remote mode: every rate code, then the divider doubling the period
    dx <= 2'b01;
    dy <= 2'b11;
    for (c = 0; c < 5; c++)
    begin
      host.txn(1'b0, 4'h2, {8'(c / 4), 16'h0}, 1, rsp);
      wb_wr(4'h1, {1'b0, 2'(c), 5'h01});
      repeat (480) @(posedge sys_clk);
      wb_wr(4'h1, 8'h00);
      e = 480 / (40 * (c % 4 + 1) * (c / 4 + 1));
      wb_xfer(1'b0, 4'h7, 8'h0, q);
      chk_rng(q, e - 1, e + 1);
      wb_xfer(1'b0, 4'h8, 8'h0, q);
      q = 8'h0 - q;
      chk_rng(q, e - 1, e + 1);
      rd_chk(4'h7, 8'h00);
    end
    chk(irq, 1'b0);
    // stream mode: motion raises irq until status is read
    wb_wr(4'h5, 8'h08);
    wb_wr(4'h1, 8'h01);
    while (irq !== 1'b1)
      @(negedge sys_clk);
    wb_wr(4'h1, 8'h00);
    dx <= 2'b00;
    dy <= 2'b00;
    wb_xfer(1'b0, 4'h0, 8'h0, q);
    chk(q[0], 1'b1);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    for (c = 6; c < 9; c++)
      wb_xfer(1'b0, 4'(c), 8'h0, q);
    // click in remote mode, read back over the serial port
    wb_wr(4'h5, 8'h02);
    wb_wr(4'h3, 8'h00);
    click <= 1'b1;
    repeat (110) @(posedge sys_clk);
    host.txn(1'b1, 4'h6, 24'h0, 3, rsp);
    chk(rsp, 24'h020000);
    rd_chk(4'h0, 8'h80);
    rd_chk(4'h6, 8'h00);
    click <= 1'b0;
    // a second touch is a second click event for the host to pair
    repeat (110) @(posedge sys_clk);
    click <= 1'b1;
    repeat (110) @(posedge sys_clk);
    rd_chk(4'h0, 8'h80);
    // heating under the watchdog, then a second request
    wb_wr(4'h4, 8'h61);
    while (heat_on !== 1'b1)
      @(negedge sys_clk);
    chk(pwr_hi, 1'b1);
    n = 0;
    while (heat_on === 1'b1)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk_rng(n, WD - 2, WD + 2);
    rd_chk(4'h4, 8'h21);
    wb_wr(4'h4, 8'h60);
    repeat (3) @(posedge sys_clk);
    chk(heat_on, 1'b1);
    chk(pwr_hi, 1'b0);
    while (heat_on === 1'b1)
      @(negedge sys_clk);
    wb_wr(4'h4, 8'h00);
    wb_wr(4'h5, 8'h04);
    repeat (3) @(posedge sys_clk);
    chk(standby, 1'b1);
    wb_wr(4'h5, 8'h00);
    repeat (3) @(posedge sys_clk);
    chk(standby, 1'b0);
    // acquisition: sync column, then column 1 rows 0 and 1
    wb_wr(4'h5, 8'h10);
    host.frame(5, fr);
    chk(fr[39:8], 32'hf0f00200);
    chk({24'h0, fr[7:0]}, 32'h12);
    report_and_stop();
  end
endmodule // tb_top
bind sns_top sns_props #(.WD_CYC(WD_CYC)) u_props (
  .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o), .heat_on_o(heat_on_o), .heat_pwr_hi_o(heat_pwr_hi_o),
  .standby_o(standby_o));
`default_nettype wire
